/* logic/usi_pkg.sv */
// Operation
// - Transmitter empty sets; holding write clears
// - Holding empty sets; holding write clears
// - Line low beyond frame sets break
// - Bad first stop bit sets framing error
// - Failed parity check sets parity error
// - Unread data overwritten sets overrun
// - Full receive register sets ready; read clears
// - Enable bit 2 raises line status interrupt
// - Enable bit 1 raises transmit empty interrupt
// - Enable bit 0 raises receive full interrupt
// - Identify register shows source, resets 0x01
// - Enable register read/write, resets 0x00
// - Identify bits 2:1 encode prioritised source
// - Holding write or identify read clears transmit
// - Receiver checks only the first stop
package usi_pkg;
	// Register byte addresses.
	localparam logic [31:0] ADDR_DATA = 32'hffff0700;
	localparam logic [31:0] ADDR_IEN = 32'hffff0704;
	localparam logic [31:0] ADDR_IID = 32'hffff0708;
	localparam logic [31:0] ADDR_LSR = 32'hffff0740;
	// Reset values.
	localparam logic [7:0] IEN_RST = 8'h00;
	localparam logic [7:0] IID_RST = 8'h01;
	// Line status bit positions.
	localparam int LSR_TRANSMITTER_FULLY_EMPTY = 6;
	localparam int LSR_TX_HOLDING_EMPTY = 5;
	localparam int LSR_BI = 4;
	localparam int LSR_FE = 3;
	localparam int LSR_PE = 2;
	localparam int LSR_OE = 1;
	localparam int LSR_DR = 0;
	// Enable bit positions.
	localparam int IEN_LS = 2;
	localparam int IEN_TX = 1;
	localparam int IEN_RX = 0;
	// Identify codes in bits 2:0, bit 0 is the no-pending flag.
	localparam logic [2:0] IID_NONE = 3'h1;
	localparam logic [2:0] IID_LS = 3'h6;
	localparam logic [2:0] IID_RX = 3'h4;
	localparam logic [2:0] IID_TX = 3'h2;
	// Longest frame in bit times: start, 8 data, parity, 2 stop.
	localparam logic [3:0] BRK_BITS = 4'hc;
endpackage

/* logic/usi_status_irq.sv */
`timescale 1ns/1ps
module usi_status_irq (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Register port.
	input wire logic [31:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Frame configuration from the control registers.
	input wire logic [1:0] word_len,
	input wire logic parity_en,
	input wire logic even_parity,
	input wire logic stick_parity,
	// Serial line and bit-time tick.
	input wire logic serial_input_line,
	input wire logic bit_tick,
	// Receiver character hand-over.
	input wire logic rx_char_done,
	input wire logic [7:0] rx_char,
	input wire logic rx_parity_bit,
	input wire logic rx_stop_bit,
	// Transmitter hand-over.
	input wire logic tx_take,
	input wire logic tx_shift_busy,
	output logic [7:0] tx_holding_data,
	output logic tx_holding_empty,
	// Interrupt request.
	output logic uart_irq
);

	////////////////////////////////////////////////////////////////////////
	// Helper functions.

	// Checks a received parity bit against the configured scheme.
	function automatic logic parity_fail(input logic [7:0] d, input logic [1:0] wl,
		input logic en, input logic eps, input logic sp, input logic pb);
		logic [7:0] m;
		logic exp_bit;
		m = 8'hff >> (3'h3 - {1'b0, wl});
		exp_bit = sp ? eps : (eps ? ^(d & m) : ~^(d & m));
		return en && (pb != exp_bit);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State.

	logic [7:0] rdata_r; // Read data, valid one cycle after the strobe.
	logic [2:0] ien_r; // Stored enable bits 2:0.
	logic [7:0] rx_r; // Receive register.
	logic [7:0] thr_r; // Transmit holding register.
	logic tx_holding_empty_r; // Holding register empty.
	logic transmitter_fully_empty_r; // Holding and shift register empty.
	logic bi_r; // Break flag.
	logic fe_r; // Framing error flag.
	logic pe_r; // Parity error flag.
	logic oe_r; // Overrun flag.
	logic dr_r; // Data ready flag.
	logic tx_irq_r; // Transmit-empty interrupt pending.
	logic irq_r; // Registered interrupt output.
	logic sin_meta_r; // First synchroniser stage.
	logic sin_sync_r; // Second synchroniser stage.
	logic [3:0] brk_cnt_r; // Low bit times counted.
	logic [3:0] brk_cnt_nxt; // Next break count.

	////////////////////////////////////////////////////////////////////////
	// Decode and combinational status.

	// Access strobes per register.
	wire thr_wr = reg_wr && (reg_addr == usi_pkg::ADDR_DATA);
	wire rx_rd = reg_rd && (reg_addr == usi_pkg::ADDR_DATA);
	wire ien_wr = reg_wr && (reg_addr == usi_pkg::ADDR_IEN);
	wire iid_rd = reg_rd && (reg_addr == usi_pkg::ADDR_IID);
	wire lsr_rd = reg_rd && (reg_addr == usi_pkg::ADDR_LSR);
	// Receive events. Only the first stop bit is ever looked at.
	wire fe_set = rx_char_done && !rx_stop_bit;
	wire pe_set = rx_char_done && parity_fail(rx_char, word_len, parity_en,
		even_parity, stick_parity, rx_parity_bit);
	wire oe_set = rx_char_done && dr_r && !rx_rd;
	// Break fires once, on the tick that passes the longest frame.
	wire brk_set = bit_tick && !sin_sync_r && (brk_cnt_r == usi_pkg::BRK_BITS);
	// Pending sources, each gated by its enable.
	wire ls_pend = ien_r[usi_pkg::IEN_LS] && (fe_r || pe_r || oe_r);
	wire rx_pend = ien_r[usi_pkg::IEN_RX] && dr_r;
	wire tx_pend = ien_r[usi_pkg::IEN_TX] && tx_irq_r;
	// Prioritised identify code.
	wire [2:0] iid_code = ls_pend ? usi_pkg::IID_LS :
		rx_pend ? usi_pkg::IID_RX :
		tx_pend ? usi_pkg::IID_TX : usi_pkg::IID_NONE;
	// Line status as read, bit 7 reserved.
	wire [7:0] lsr_val = {1'b0, transmitter_fully_empty_r, tx_holding_empty_r, bi_r, fe_r, pe_r, oe_r, dr_r};
	// Read multiplexer, unmapped addresses read zero.
	wire [7:0] rd_mux = (reg_addr == usi_pkg::ADDR_DATA) ? rx_r :
		(reg_addr == usi_pkg::ADDR_IEN) ? {5'h00, ien_r} :
		(reg_addr == usi_pkg::ADDR_IID) ? {5'h00, iid_code} :
		(reg_addr == usi_pkg::ADDR_LSR) ? lsr_val : 8'h00;

	// Break counter saturates while the line stays low, restarts on high.
	always_comb begin
		brk_cnt_nxt = brk_cnt_r;
		if (sin_sync_r) begin
			brk_cnt_nxt = 4'h0;
		end else if (bit_tick && (brk_cnt_r != 4'hf)) begin
			brk_cnt_nxt = brk_cnt_r + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers.

	// Bus read data and enable register.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdata_r <= 8'h00;
			ien_r <= usi_pkg::IEN_RST[2:0];
		end else begin
			rdata_r <= reg_rd ? rd_mux : 8'h00;
			if (ien_wr) begin
				ien_r <= reg_wdata[2:0];
			end
		end
	end

	// Serial input synchroniser and break counter.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sin_meta_r <= 1'b1;
			sin_sync_r <= 1'b1;
			brk_cnt_r <= 4'h0;
		end else begin
			sin_meta_r <= serial_input_line;
			sin_sync_r <= sin_meta_r;
			brk_cnt_r <= brk_cnt_nxt;
		end
	end

	// Transmit holding register and its empty flags.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			thr_r <= 8'h00;
			tx_holding_empty_r <= 1'b1;
			transmitter_fully_empty_r <= 1'b1;
		end else begin
			if (thr_wr) begin
				thr_r <= reg_wdata;
				tx_holding_empty_r <= 1'b0;
				transmitter_fully_empty_r <= 1'b0;
			end else begin
				// The transmitter taking the byte empties the holding register.
				tx_holding_empty_r <= tx_holding_empty_r || tx_take;
				transmitter_fully_empty_r <= tx_holding_empty_r && !tx_shift_busy && !tx_take;
			end
		end
	end

	// Transmit-empty interrupt, a new emptying wins over an identify read clear, a holding write wins over both.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_irq_r <= 1'b0;
		end else if (tx_take && !thr_wr) begin
			tx_irq_r <= 1'b1;
		end else if (thr_wr || (iid_rd && iid_code == usi_pkg::IID_TX)) begin
			tx_irq_r <= 1'b0;
		end
	end

	// Receive register and data ready, a new character wins over a read.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rx_r <= 8'h00;
			dr_r <= 1'b0;
		end else if (rx_char_done) begin
			rx_r <= rx_char;
			dr_r <= 1'b1;
		end else if (rx_rd) begin
			dr_r <= 1'b0;
		end
	end

	// Error flags: a status read clears them unless an event lands together.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bi_r <= 1'b0;
			fe_r <= 1'b0;
			pe_r <= 1'b0;
			oe_r <= 1'b0;
		end else begin
			bi_r <= brk_set || (bi_r && !lsr_rd);
			fe_r <= fe_set || (fe_r && !lsr_rd);
			pe_r <= pe_set || (pe_r && !lsr_rd);
			oe_r <= oe_set || (oe_r && !lsr_rd);
		end
	end

	// Interrupt output follows the pending sources one cycle later.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= ls_pend || rx_pend || tx_pend;
		end
	end

	// Outputs straight from flip-flops.
	assign reg_rdata = rdata_r;
	assign tx_holding_data = thr_r;
	assign tx_holding_empty = tx_holding_empty_r;
	assign uart_irq = irq_r;

	////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// A holding write empties neither flag on the next cycle.
	property p_transmitter_fully_empty_clr;
		thr_wr |=> !transmitter_fully_empty_r && !tx_holding_empty_r;
	endproperty
	a_transmitter_fully_empty_clr: assert property (p_transmitter_fully_empty_clr) else $error("empty flags not cleared");

	// Fully empty implies holding empty.
	property p_transmitter_fully_empty_tx_holding_empty;
		transmitter_fully_empty_r |-> tx_holding_empty_r;
	endproperty
	a_transmitter_fully_empty_tx_holding_empty: assert property (p_transmitter_fully_empty_tx_holding_empty) else $error("transmitter_fully_empty without tx_holding_empty");

	// Transmitter taking the byte sets holding empty.
	property p_tx_holding_empty_set;
		tx_take && !thr_wr |=> tx_holding_empty_r;
	endproperty
	a_tx_holding_empty_set: assert property (p_tx_holding_empty_set) else $error("tx_holding_empty not set");

	// Break passes the longest frame before flagging.
	property p_brk;
		brk_set |-> brk_cnt_r == usi_pkg::BRK_BITS ##1 bi_r;
	endproperty
	a_brk: assert property (p_brk) else $error("break not flagged");

	// Bad stop bit flags framing.
	property p_fe;
		rx_char_done && !rx_stop_bit |=> fe_r;
	endproperty
	a_fe: assert property (p_fe) else $error("framing not flagged");

	// Overwrite of unread data flags overrun.
	property p_oe;
		rx_char_done && dr_r && !rx_rd |=> oe_r && dr_r;
	endproperty
	a_oe: assert property (p_oe) else $error("overrun not flagged");

	// Reading the receive register clears ready.
	property p_dr_clr;
		rx_rd && !rx_char_done |=> !dr_r;
	endproperty
	a_dr_clr: assert property (p_dr_clr) else $error("ready not cleared");

	// Status read with no new event clears the error bits.
	property p_lsr_clr;
		lsr_rd && !rx_char_done && !brk_set |=> !(bi_r || fe_r || pe_r || oe_r);
	endproperty
	a_lsr_clr: assert property (p_lsr_clr) else $error("errors not cleared");

	// Identify read returns the code pending at the strobe.
	property p_iid_rd;
		iid_rd |=> reg_rdata == {5'h00, $past(iid_code)};
	endproperty
	a_iid_rd: assert property (p_iid_rd) else $error("identify read wrong");

	// Line status has priority in the identify code.
	property p_iid_pri;
		ls_pend |-> iid_code == usi_pkg::IID_LS;
	endproperty
	a_iid_pri: assert property (p_iid_pri) else $error("priority wrong");

	// Interrupt output tracks the enabled sources.
	property p_irq;
		##1 irq_r == $past(iid_code != usi_pkg::IID_NONE);
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");

	// Reading a transmit identify clears that source.
	property p_tx_clr;
		iid_rd && iid_code == usi_pkg::IID_TX && !tx_take |=> !tx_irq_r;
	endproperty
	a_tx_clr: assert property (p_tx_clr) else $error("tx irq not cleared");

	// An enable write lands in the stored bits, bit 3 and up read zero.
	property p_ien_wr;
		ien_wr |=> {5'h00, ien_r} == ($past(reg_wdata) & 8'h07);
	endproperty
	a_ien_wr: assert property (p_ien_wr) else $error("enable write lost");

	// Status reads always show the reserved top bit as zero.
	property p_lsr_top;
		lsr_rd |=> !reg_rdata[7];
	endproperty
	a_lsr_top: assert property (p_lsr_top) else $error("status bit 7 set");

	// An enabled received character raises the output two cycles later.
	property p_rx_irq;
		rx_char_done && ien_r[usi_pkg::IEN_RX] && !ien_wr |-> ##2 irq_r;
	endproperty
	a_rx_irq: assert property (p_rx_irq) else $error("rx irq missing");

	// An enabled take of the holding byte raises the output two cycles later.
	property p_tx_irq;
		tx_take && !thr_wr && ien_r[usi_pkg::IEN_TX] && !ien_wr |-> ##2 irq_r;
	endproperty
	a_tx_irq: assert property (p_tx_irq) else $error("tx irq missing");

	// Main scenarios.
	c_break: cover property (brk_set);
	c_overrun: cover property (oe_set ##[1:50] lsr_rd);
	c_tx_irq: cover property (tx_pend ##1 irq_r ##[1:50] thr_wr);
	c_ls_irq: cover property (ls_pend && rx_pend);

endmodule

/* verif/usi_far_node.sv */
`timescale 1ns/1ps
// Far node: bit timing, receiver hand-over and a transmitter that drains.
module usi_far_node (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Commands from the bench and the holding-empty flag from the block.
	input wire logic rx_go,
	input wire logic [7:0] go_char,
	input wire logic go_par,
	input wire logic go_stop,
	input wire logic line_low,
	input wire logic tx_holding_empty,
	// Lines into the block.
	output logic serial_input_line,
	output logic bit_tick,
	output logic rx_char_done,
	output logic [7:0] rx_char,
	output logic rx_parity_bit,
	output logic rx_stop_bit,
	output logic tx_take,
	output logic tx_shift_busy
);
	logic [1:0] tick_r; // Bit time divider.
	logic [3:0] take_r; // Delay before a take.
	logic [3:0] busy_r; // Shift time left.
	logic [9:0] char_r; // Last character, parity and stop.
	// Outside a hand-over the fields show the inverse of the last ones.
	assign rx_char = rx_char_done ? char_r[9:2] : ~char_r[9:2];
	assign rx_parity_bit = rx_char_done ? char_r[1] : ~char_r[1];
	assign rx_stop_bit = rx_char_done ? char_r[0] : ~char_r[0];
	assign tx_shift_busy = (busy_r != 4'h0);
	// One process steps every counter.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tick_r <= 2'h0;
			take_r <= 4'h0;
			busy_r <= 4'h0;
			char_r <= 10'h000;
			bit_tick <= 1'b0;
			rx_char_done <= 1'b0;
			tx_take <= 1'b0;
			serial_input_line <= 1'b1;
		end else begin
			tick_r <= tick_r + 2'h1;
			bit_tick <= (tick_r == 2'h3);
			serial_input_line <= ~line_low;
			rx_char_done <= rx_go;
			if (rx_go) begin
				char_r <= {go_char, go_par, go_stop};
			end
			// Take the holding byte four cycles after it fills.
			tx_take <= (take_r == 4'h3) && !tx_holding_empty;
			if (tx_holding_empty) begin
				take_r <= 4'h0;
			end else if (take_r != 4'h4) begin
				take_r <= take_r + 4'h1;
			end
			if (tx_take) begin
				busy_r <= 4'h8;
			end else if (busy_r != 4'h0) begin
				busy_r <= busy_r - 4'h1;
			end
		end
	end
endmodule

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
	logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [31:0] reg_addr = 32'h00000000;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, tx_holding_data, rx_char, go_char = 8'h00;
	logic [1:0] word_len = 2'h3;
	logic parity_en = 1'b0, even_parity = 1'b0, serial_input_line, bit_tick, rx_char_done;
	logic rx_parity_bit, rx_stop_bit, tx_take, tx_shift_busy, tx_holding_empty, uart_irq;
	logic rx_go = 1'b0, go_par = 1'b0, go_stop = 1'b1, line_low = 1'b0;
	logic stick_parity = 1'b0;
	int err_total = 0, checked = 0, cyc = 0;
	usi_status_irq i_usi_status_irq (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.word_len(word_len), .parity_en(parity_en), .even_parity(even_parity),
		.stick_parity(stick_parity), .serial_input_line(serial_input_line),
		.bit_tick(bit_tick),
		.rx_char_done(rx_char_done), .rx_char(rx_char), .rx_parity_bit(rx_parity_bit),
		.rx_stop_bit(rx_stop_bit), .tx_take(tx_take), .tx_shift_busy(tx_shift_busy),
		.tx_holding_data(tx_holding_data), .tx_holding_empty(tx_holding_empty),
		.uart_irq(uart_irq));
	usi_far_node i_usi_far_node (.sys_clk(sys_clk), .rst(rst), .rx_go(rx_go),
		.go_char(go_char), .go_par(go_par), .go_stop(go_stop), .line_low(line_low),
		.tx_holding_empty(tx_holding_empty), .serial_input_line(serial_input_line),
		.bit_tick(bit_tick), .rx_char_done(rx_char_done), .rx_char(rx_char),
		.rx_parity_bit(rx_parity_bit), .rx_stop_bit(rx_stop_bit), .tx_take(tx_take),
		.tx_shift_busy(tx_shift_busy));
	////////////////////////////////////////////////////////////////////////////////
	// Clock at 8 ns and a cycle ceiling against hangs.
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total = err_total + 1;
			finish_test();
		end
	end
	// Counts, verdict and end of run.
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Compare one byte or one flag.
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checked = checked + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask
	// One-cycle write, and a read whose data stand in the next cycle.
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdc(input logic [31:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk8(reg_rdata, exp);
	endtask
	// Hand one character to the block and let its flags settle.
	task automatic snd(input logic [7:0] c, input logic p, input logic s);
		@(posedge sys_clk);
		rx_go <= 1'b1;
		go_char <= c;
		go_par <= p;
		go_stop <= s;
		@(posedge sys_clk);
		rx_go <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask
	task automatic gap(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		gap(2);
		rst <= 1'b0;
		// Reset values and an unmapped place.
		rdc(usi_pkg::ADDR_IEN, usi_pkg::IEN_RST);
		rdc(usi_pkg::ADDR_IID, usi_pkg::IID_RST);
		rdc(usi_pkg::ADDR_LSR, 8'h60);
		rdc(32'hffff0744, 8'h00);
		chk1(uart_irq, 1'b0);
		wr(usi_pkg::ADDR_IEN, 8'h07);
		rdc(usi_pkg::ADDR_IEN, 8'h07);
		$display("test reset done");
		// Transmit: flags drop on a write, tx interrupt cleared both ways.
		wr(usi_pkg::ADDR_DATA, 8'h5a);
		rdc(usi_pkg::ADDR_LSR, 8'h00);
		chk8(tx_holding_data, 8'h5a);
		gap(30);
		chk1(uart_irq, 1'b1);
		rdc(usi_pkg::ADDR_LSR, 8'h60);
		wr(usi_pkg::ADDR_DATA, 8'h33);
		gap(2);
		chk1(uart_irq, 1'b0);
		gap(30);
		chk1(uart_irq, 1'b1);
		rdc(usi_pkg::ADDR_IID, 8'h02);
		gap(2);
		chk1(uart_irq, 1'b0);
		$display("test transmit done");
		// Receive: ready, rx interrupt, read clears.
		snd(8'h41, 1'b0, 1'b1);
		chk1(uart_irq, 1'b1);
		rdc(usi_pkg::ADDR_IID, 8'h04);
		rdc(usi_pkg::ADDR_LSR, 8'h61);
		rdc(usi_pkg::ADDR_DATA, 8'h41);
		rdc(usi_pkg::ADDR_LSR, 8'h60);
		chk1(uart_irq, 1'b0);
		// Framing error outranks the full buffer.
		snd(8'h22, 1'b0, 1'b0);
		rdc(usi_pkg::ADDR_IID, 8'h06);
		rdc(usi_pkg::ADDR_LSR, 8'h69);
		rdc(usi_pkg::ADDR_LSR, 8'h61);
		rdc(usi_pkg::ADDR_DATA, 8'h22);
		$display("test receive done");
		// Bad even parity, then an unread overwrite.
		parity_en <= 1'b1;
		even_parity <= 1'b1;
		snd(8'h01, 1'b0, 1'b1);
		snd(8'h03, 1'b0, 1'b1);
		rdc(usi_pkg::ADDR_LSR, 8'h67);
		rdc(usi_pkg::ADDR_LSR, 8'h61);
		rdc(usi_pkg::ADDR_DATA, 8'h03);
		// Five-bit words leave the upper bits out of the even parity sum.
		word_len <= 2'h0;
		snd(8'he0, 1'b0, 1'b1);
		rdc(usi_pkg::ADDR_LSR, 8'h61);
		rdc(usi_pkg::ADDR_DATA, 8'he0);
		// Stick parity with the select low expects a zero parity bit.
		even_parity <= 1'b0;
		stick_parity <= 1'b1;
		snd(8'h00, 1'b1, 1'b1);
		rdc(usi_pkg::ADDR_LSR, 8'h65);
		rdc(usi_pkg::ADDR_DATA, 8'h00);
		parity_en <= 1'b0;
		stick_parity <= 1'b0;
		word_len <= 2'h3;
		// Line held low beyond a full frame.
		line_low <= 1'b1;
		gap(80);
		line_low <= 1'b0;
		gap(4);
		rdc(usi_pkg::ADDR_LSR, 8'h70);
		rdc(usi_pkg::ADDR_LSR, 8'h60);
		$display("test errors done");
		// Disabled sources raise nothing.
		wr(usi_pkg::ADDR_IEN, 8'h00);
		snd(8'h11, 1'b0, 1'b1);
		chk1(uart_irq, 1'b0);
		rdc(usi_pkg::ADDR_DATA, 8'h11);
		$display("test mask done");
		finish_test();
	end
endmodule
